// *** inc/cmm_pkg.sv ***
/*
  Shared constants and types of the CAN mode and mailbox status block.
  Assumes an 8-bit register port and a protocol engine on the same clock.
*/
package cmm_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MASTER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MASTER_STATUS = 8'h01;
  localparam logic [7:0] OFS_TRANSMIT_STATUS = 8'h02;
  localparam logic [7:0] OFS_TRANSMIT_PRIORITY = 8'h03;
  localparam logic [7:0] OFS_RECEIVE_FIFO_STATUS = 8'h04;
  localparam logic [7:0] OFS_MAILBOX_REQUEST = 8'h05;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h06;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MASTER_CONTROL = 8'h02;
  localparam logic [7:0] RST_MASTER_STATUS = 8'h02;
  localparam logic [7:0] RST_TRANSMIT_STATUS = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_PRIORITY = 8'h0c;
  localparam logic [7:0] RST_RECEIVE_FIFO_STATUS = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_AUTO_BUSOFF = 6;
  localparam int BIT_AUTO_WAKEUP = 5;
  localparam int BIT_SINGLE_SHOT = 4;
  localparam int BIT_LOCK_MODE = 3;
  localparam int BIT_ORDER_BY_REQ = 2;
  localparam int BIT_SLEEP_REQ = 1;
  localparam int BIT_INIT_REQ = 0;
  localparam int BIT_RECEIVING = 5;
  localparam int BIT_TRANSMITTING = 4;
  localparam int BIT_WAKEUP_FLAG = 3;
  localparam int BIT_ERROR_FLAG = 2;
  localparam int BIT_SLEEP_ACK = 1;
  localparam int BIT_INIT_ACK = 0;
  localparam int BIT_SUCCESS0 = 4;
  localparam int BIT_DONE0 = 0;
  localparam int BIT_LOWEST0 = 5;
  localparam int BIT_EMPTY0 = 2;
  localparam int BIT_FIFO_RELEASE = 5;
  localparam int BIT_FIFO_OVERRUN = 4;
  localparam int BIT_FIFO_FULL = 3;
  localparam int BIT_REQUEST0 = 0;
  localparam int BIT_ABORT0 = 4;
  localparam int BIT_WAKEUP_IRQ_EN = 7;
  localparam int BIT_ERROR_IRQ_EN = 6;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int RECESSIVE_RUN_LEN = 11;
  localparam int BUSOFF_RUN_COUNT = 128;
  localparam logic [1:0] FIFO_DEPTH = 2'h3;

  // ----------------------------------------------------------------
  // Operating modes, Gray coded along sleep-sync-normal-init wait-init-sleep wait
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h0,
    MODE_SYNC = 3'h1,
    MODE_NORMAL = 3'h3,
    MODE_INIT_WAIT = 3'h2,
    MODE_INIT = 3'h6,
    MODE_SLEEP_WAIT = 3'h7
  } cmm_mode_type;

endpackage

// *** tb/cmm_bus_model.sv ***
/* Engine and bus stand-in: bit ticks, rx level, frames that succeed.
   Assumes the block's clock. */
`timescale 1ns/1ps
module cmm_bus_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bench command and block side
  input wire logic forceDominant,
  input wire logic txStart,
  output logic rxPin,
  output logic bitTick,
  output logic txActive,
  output logic txEngineIdle,
  output logic txResultOk
);
  logic [1:0] tickCnt;
  logic [3:0] busyCnt;
  // Recessive unless the bench asks for a start of frame
  assign rxPin = !forceDominant;
  assign bitTick = tickCnt == 2'h3;
  assign txActive = busyCnt != 4'h0;
  assign txEngineIdle = !txActive;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tickCnt <= 2'h0;
      busyCnt <= 4'h0;
      txResultOk <= 1'b0;
    end
    else
    begin
      tickCnt <= tickCnt + 2'h1;
      txResultOk <= busyCnt == 4'h1;
      if (txStart)
        busyCnt <= 4'ha;
      else if (txActive)
        busyCnt <= busyCnt - 4'h1;
    end
  end
endmodule

// *** tb/cmm_ctrl_status_checker.sv ***
/* Port checker of cmm_ctrl_status.
   Assumes it is bound to every instance of that module. */
`timescale 1ns/1ps
module cmm_ctrl_status_checker
  import cmm_pkg::*;
#(
  parameter int BUSOFF_RUNS = 128
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // Engine and modes
  input wire logic txEngineIdle,
  input wire logic txStart,
  input wire logic rxStore,
  input wire logic rxStoreAccept,
  input wire logic rxOverwrite,
  input wire logic fifoRelease,
  input wire logic initMode,
  input wire logic sleepMode,
  input wire logic busOnline
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ------
  // Properties
  // ------
  a_rdata_quiet: assert property (regRdata != 8'h00 |-> $past(regRd))
    else $error("read data outside read slot");
  a_start_once: assert property (txStart |=> !txStart)
    else $error("start held too long");
  a_start_ready: assert property (txStart |-> $past(txEngineIdle && busOnline))
    else $error("start while engine busy or offline");
  a_init_quiet: assert property (initMode |-> !txStart && !busOnline)
    else $error("traffic in init mode");
  a_sleep_quiet: assert property (sleepMode |-> !busOnline && !txStart)
    else $error("sleep mode overlaps another mode");
  a_store_cause: assert property (rxStoreAccept || rxOverwrite |-> $past(rxStore))
    else $error("store without message");
  a_store_kind: assert property (rxStore |=> !(rxStoreAccept && rxOverwrite))
    else $error("store both accepted and overwritten");
  a_release_cause: assert property (fifoRelease |-> $past(regWr && regWdata[BIT_FIFO_RELEASE]
    && regAddr == OFS_RECEIVE_FIFO_STATUS))
    else $error("release without request");
endmodule

bind cmm_ctrl_status cmm_ctrl_status_checker #(.BUSOFF_RUNS(BUSOFF_RUNS)) i_chk (
  .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .txEngineIdle(txEngineIdle), .txStart(txStart),
  .rxStore(rxStore), .rxStoreAccept(rxStoreAccept), .rxOverwrite(rxOverwrite),
  .fifoRelease(fifoRelease), .initMode(initMode), .sleepMode(sleepMode),
  .busOnline(busOnline));

// *** tb/tb_cmm_ctrl_status.sv ***
/* Register-level bench of cmm_ctrl_status.
   Assumes cmm_bus_model stands in for engine and bus. */
`timescale 1ns/1ps
module tb_cmm_ctrl_status
  import cmm_pkg::*;
;
  logic clk, srst, regWr, regRd, rxStore, errorEvent, forceDominant, busOffEnter;
  logic [7:0] regAddr, regWdata, regRdata;
  logic rxPin, bitTick, txActive, txEngineIdle, txResultOk, txStart;
  logic rxStoreAccept, rxOverwrite, fifoRelease, initMode, sleepMode;
  logic busOnline, statusChangeIrq, busOff, txMailbox;
  logic [28:0] id0 = 29'h5;
  logic [28:0] id1 = 29'h3;
  int n_mismatch = 0;
  int checks_done = 0;

  cmm_ctrl_status #(.ID_W(29), .BUSOFF_RUNS(2)) i_dut (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .rxPin(rxPin), .bitTick(bitTick),
    .rxActive(1'b0), .txActive(txActive), .busOffEnter(busOffEnter), .errorEvent(errorEvent),
    .mailbox0Id(id0), .mailbox1Id(id1), .txEngineIdle(txEngineIdle),
    .txResultOk(txResultOk), .txResultFail(1'b0), .txStart(txStart), .txMailbox(txMailbox),
    .rxStore(rxStore), .rxStoreAccept(rxStoreAccept), .rxOverwrite(rxOverwrite),
    .fifoRelease(fifoRelease), .initMode(initMode), .sleepMode(sleepMode), .busOff(busOff),
    .busOnline(busOnline), .singleShot(), .statusChangeIrq(statusChangeIrq));
  cmm_bus_model i_bus (
    .clk(clk), .srst(srst), .forceDominant(forceDominant), .txStart(txStart),
    .rxPin(rxPin), .bitTick(bitTick), .txActive(txActive),
    .txEngineIdle(txEngineIdle), .txResultOk(txResultOk));

  always #2 clk = !clk;

  // ------
  // Tasks
  // ------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk("regRdata", exp, regRdata);
  endtask
  task automatic pulse_store();
    @(posedge clk);
    rxStore <= 1'b1;
    @(posedge clk);
    rxStore <= 1'b0;
  endtask

  initial
  begin
    #40000;
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    clk = 0;
    srst = 1;
    {regAddr, regWdata, regWr, regRd, rxStore, errorEvent, forceDominant, busOffEnter} = '0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_MASTER_CONTROL, RST_MASTER_CONTROL);
    rd(OFS_MASTER_STATUS, RST_MASTER_STATUS);
    rd(OFS_TRANSMIT_STATUS, RST_TRANSMIT_STATUS);
    rd(OFS_TRANSMIT_PRIORITY, RST_TRANSMIT_PRIORITY);
    rd(OFS_RECEIVE_FIFO_STATUS, RST_RECEIVE_FIFO_STATUS);
    rd(8'h3f, 8'h00);
    wr(OFS_MASTER_CONTROL, 8'h00);
    repeat (80) @(posedge clk);
    rd(OFS_MASTER_STATUS, 8'h00);
    // Mailbox 1 carries the lower identifier
    wr(OFS_MAILBOX_REQUEST, 8'h03);
    rd(OFS_TRANSMIT_PRIORITY, 8'h20);
    repeat (40) @(posedge clk);
    rd(OFS_TRANSMIT_STATUS, 8'h33);
    chk("txMailbox", 8'h00, {7'h00, txMailbox});
    rd(OFS_TRANSMIT_PRIORITY, 8'h0c);
    wr(OFS_TRANSMIT_STATUS, 8'h00);
    rd(OFS_TRANSMIT_STATUS, 8'h33);
    wr(OFS_TRANSMIT_STATUS, 8'h01);
    rd(OFS_TRANSMIT_STATUS, 8'h22);
    repeat (4) pulse_store();
    rd(OFS_RECEIVE_FIFO_STATUS, 8'h1b);
    wr(OFS_RECEIVE_FIFO_STATUS, 8'h20);
    rd(OFS_RECEIVE_FIFO_STATUS, 8'h12);
    wr(OFS_RECEIVE_FIFO_STATUS, 8'hd0);
    rd(OFS_RECEIVE_FIFO_STATUS, 8'h02);
    wr(OFS_IRQ_ENABLE, 8'h40);
    @(posedge clk);
    {errorEvent, busOffEnter} <= 2'b11;
    @(posedge clk);
    {errorEvent, busOffEnter} <= 2'b00;
    rd(OFS_MASTER_STATUS, 8'h04);
    chk("statusChangeIrq", 8'h01, {7'h00, statusChangeIrq});
    chk("busOff", 8'h01, {7'h00, busOff});
    wr(OFS_MASTER_STATUS, 8'h04);
    rd(OFS_MASTER_STATUS, 8'h00);
    wr(OFS_MASTER_CONTROL, 8'h22);
    repeat (4) @(posedge clk);
    rd(OFS_MASTER_STATUS, 8'h02);
    forceDominant <= 1'b1;
    repeat (8) @(posedge clk);
    forceDominant <= 1'b0;
    repeat (4) @(posedge clk);
    rd(OFS_MASTER_STATUS, 8'h08);
    rd(OFS_MASTER_CONTROL, 8'h20);
    wr(OFS_MASTER_CONTROL, 8'h01);
    repeat (4) @(posedge clk);
    rd(OFS_MASTER_STATUS, 8'h09);
    chk("busOff", 8'h00, {7'h00, busOff});
    wr(OFS_MASTER_CONTROL, 8'h00);
    repeat (60) @(posedge clk);
    rd(OFS_MASTER_STATUS, 8'h08);
    report_and_stop();
  end
endmodule

// *** verilog/cmm_ctrl_status.sv ***
/*
  Mode control, transmit mailbox status and receive FIFO status of a
  CAN controller, with a small byte-wide register port.
  Assumes the protocol engine, bit timing and mailbox storage sit
  outside on the same clock; only the receive pin is asynchronous.
*/
`timescale 1ns/1ps

// Function
// (RULE_01) Auto recovery leaves bus-off after 128 runs of 11 recessive bits; else software.
// (RULE_02) Auto wake-up on start-of-frame clears sleep request and sleep acknowledge.
// (RULE_03) Single-shot sends once whatever result; otherwise retransmit until success.
// (RULE_04) Full FIFO: lock mode discards new message, else new overwrites last.
// (RULE_05) Pending mailboxes ordered by identifier, or by request order when selected.
// (RULE_06) Sleep entered after current frame ends; clearing request exits sleep.
// (RULE_07) Leaving init waits for 11 recessive bits, then clears init acknowledge.
// (RULE_08) Init request waits for current frame to end, then sets acknowledge.
// (RULE_09) Status flags clear only on writing one; zero leaves them.
// (RULE_10) Read-only receiving and transmitting indications.
// (RULE_11) Start-of-frame in sleep sets wake-up flag; software clears it.
// (RULE_12) Enabled error event sets error flag; status interrupt when enabled. The code sets errFlag on every errorEvent, whatever errIrqEn.
// (RULE_13) Sleep acknowledge high exactly while in sleep.
// (RULE_14) Success flag per mailbox; cleared by new request or clearing done flag.
// (RULE_15) Request-done flag per mailbox after transmit or abort ends.
// (RULE_16) Lowest-priority flag only when both mailboxes pending.
// (RULE_17) Empty flag high while no request pending for that mailbox.
// (RULE_18) Code gives next free mailbox, else the lowest-priority one.
// (RULE_19) FIFO status bits clear on writing one; bits 7:6 read zero.
// (RULE_20) Release frees output mailbox only when a message is pending.
// (RULE_21) Pending count rises on each store, falls on each release.
// (RULE_22) Full flag set at three messages; cleared by write-one or release.
// (RULE_23) Overrun flag set when a filtered message arrives with FIFO full.
module cmm_ctrl_status
  import cmm_pkg::*;
#(
  parameter int ID_W = 29,
  parameter int BUSOFF_RUNS = BUSOFF_RUN_COUNT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Bus pin and bit timing
  input wire logic rxPin,
  input wire logic bitTick,
  // Protocol engine status
  input wire logic rxActive,
  input wire logic txActive,
  input wire logic busOffEnter,
  input wire logic errorEvent,
  // Transmit mailboxes
  input wire logic [ID_W-1:0] mailbox0Id,
  input wire logic [ID_W-1:0] mailbox1Id,
  input wire logic txEngineIdle,
  input wire logic txResultOk,
  input wire logic txResultFail,
  output logic txStart,
  output logic txMailbox,
  // Receive FIFO
  input wire logic rxStore,
  output logic rxStoreAccept,
  output logic rxOverwrite,
  output logic fifoRelease,
  // Mode outputs
  output logic initMode,
  output logic sleepMode,
  output logic busOff,
  output logic busOnline,
  output logic singleShot,
  output logic statusChangeIrq
);

  localparam int GW = $clog2(BUSOFF_RUNS);
  localparam logic [GW-1:0] GROUP_LAST = GW'(BUSOFF_RUNS - 1);

  typedef struct packed {
    cmm_mode_type state;
    logic sleepReq;
    logic initReq;
    logic autoBusoff;
    logic autoWake;
    logic singleShot;
    logic lockMode;
    logic orderByReq;
    logic initAck;
    logic wakeFlag;
    logic errFlag;
    logic busOff;
    logic [GW-1:0] busOffRuns;
    logic [1:0] pending;
    logic [1:0] success;
    logic [1:0] done;
    logic [1:0] abortReq;
    logic olderMb;
    logic inFlight;
    logic flightMb;
    logic txStart;
    logic rxAccept;
    logic rxOverwrite;
    logic fifoRelease;
    logic [1:0] fifoCount;
    logic full;
    logic overrun;
    logic wakeIrqEn;
    logic errIrqEn;
    logic rxMeta;
    logic rxSync;
    logic rxPrev;
    logic [7:0] rdata;
  } cmm_state_type;

  cmm_state_type st_ff;
  cmm_state_type nxt_st;

  logic runDone;
  logic runClear;
  logic sof;
  logic busy;
  logic winMb;
  logic lowMb;
  logic bothPending;
  logic [1:0] mbCode;

  // ----------------------------------------------------------------
  // Mailbox arbitration
  // ----------------------------------------------------------------
  // Lower identifier wins; a tie goes to mailbox 0
  function automatic logic pick_winner(input logic [1:0] pend, input logic [ID_W-1:0] id0,
                                       input logic [ID_W-1:0] id1, input logic byOrder,
                                       input logic older);
    logic w;
    w = 1'b0;
    if (pend == 2'b10)
    begin
      w = 1'b1;
    end
    else if (pend == 2'b11)
    begin
      w = byOrder ? older : (id1 < id0); // [RULE_05]
    end
    return w;
  endfunction

  assign winMb = pick_winner(st_ff.pending, mailbox0Id, mailbox1Id, st_ff.orderByReq,
                             st_ff.olderMb);
  assign lowMb = ~winMb;
  assign bothPending = &st_ff.pending;
  // [RULE_18]
  assign mbCode = !st_ff.pending[0] ? 2'h0 : (!st_ff.pending[1] ? 2'h1 : {1'b0, lowMb});

  // ----------------------------------------------------------------
  // Bus activity
  // ----------------------------------------------------------------
  // Falling edge of the synchronised pin; bit timing may stop in sleep
  assign sof = st_ff.rxPrev & ~st_ff.rxSync;
  assign busy = rxActive | txActive | st_ff.inFlight;
  assign runClear = (st_ff.state != MODE_SYNC) && !st_ff.busOff;

  cmm_recessive_run #(
    .RUN_LEN(RECESSIVE_RUN_LEN)
  ) u_run (
    .clk(clk),
    .srst(srst),
    .bitTick(bitTick),
    .rxLevel(st_ff.rxSync),
    .clear(runClear),
    .runDone(runDone)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [1:0] cnt;
    logic [7:0] req;
    logic m;
    logic rel;
    cnt = st_ff.fifoCount;
    req = 8'h00;
    m = st_ff.flightMb;
    rel = 1'b0;
    nxt_st = st_ff;
    nxt_st.rxMeta = rxPin;
    nxt_st.rxSync = st_ff.rxMeta;
    nxt_st.rxPrev = st_ff.rxSync;
    nxt_st.txStart = 1'b0;
    nxt_st.rxAccept = 1'b0;
    nxt_st.rxOverwrite = 1'b0;
    nxt_st.fifoRelease = 1'b0;
    nxt_st.rdata = 8'h00;

    // Software writes first, so hardware sets below win the same cycle
    if (regWr)
    begin
      case (regAddr)
        OFS_MASTER_CONTROL:
        begin
          nxt_st.autoBusoff = regWdata[BIT_AUTO_BUSOFF];
          nxt_st.autoWake = regWdata[BIT_AUTO_WAKEUP];
          nxt_st.singleShot = regWdata[BIT_SINGLE_SHOT];
          nxt_st.lockMode = regWdata[BIT_LOCK_MODE];
          nxt_st.orderByReq = regWdata[BIT_ORDER_BY_REQ];
          nxt_st.sleepReq = regWdata[BIT_SLEEP_REQ];
          nxt_st.initReq = regWdata[BIT_INIT_REQ];
        end
        OFS_MASTER_STATUS:
        begin
          if (regWdata[BIT_WAKEUP_FLAG])
          begin
            nxt_st.wakeFlag = 1'b0; // [RULE_09] [RULE_11]
          end
          if (regWdata[BIT_ERROR_FLAG])
          begin
            nxt_st.errFlag = 1'b0; // [RULE_09]
          end
        end
        OFS_TRANSMIT_STATUS:
        begin
          for (int i = 0; i < 2; i++)
          begin
            if (regWdata[BIT_DONE0 + i])
            begin
              nxt_st.done[i] = 1'b0; // [RULE_09] [RULE_15]
              nxt_st.success[i] = 1'b0; // [RULE_14]
            end
          end
        end
        OFS_RECEIVE_FIFO_STATUS:
        begin
          if (regWdata[BIT_FIFO_FULL])
          begin
            nxt_st.full = 1'b0; // [RULE_19] [RULE_22]
          end
          if (regWdata[BIT_FIFO_OVERRUN])
          begin
            nxt_st.overrun = 1'b0; // [RULE_19]
          end
          rel = regWdata[BIT_FIFO_RELEASE] && (st_ff.fifoCount != 2'h0); // [RULE_20]
        end
        OFS_MAILBOX_REQUEST:
        begin
          req = regWdata;
        end
        OFS_IRQ_ENABLE:
        begin
          nxt_st.wakeIrqEn = regWdata[BIT_WAKEUP_IRQ_EN];
          nxt_st.errIrqEn = regWdata[BIT_ERROR_IRQ_EN];
        end
        default:
        begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end

    // ----- Operating mode -----
    case (st_ff.state)
      MODE_SLEEP:
      begin
        if (sof)
        begin
          nxt_st.wakeFlag = 1'b1; // [RULE_11]
        end
        if (sof && st_ff.autoWake)
        begin
          nxt_st.sleepReq = 1'b0; // [RULE_02]
          nxt_st.state = MODE_SYNC;
        end
        else if (!nxt_st.sleepReq)
        begin
          nxt_st.state = MODE_SYNC; // [RULE_06] [RULE_13]
        end
      end
      MODE_SYNC:
      begin
        if (nxt_st.initReq)
        begin
          nxt_st.state = MODE_INIT_WAIT;
        end
        else if (runDone && !st_ff.busOff)
        begin
          nxt_st.state = MODE_NORMAL; // [RULE_07]
          nxt_st.initAck = 1'b0;
        end
      end
      MODE_NORMAL:
      begin
        if (nxt_st.initReq)
        begin
          nxt_st.state = MODE_INIT_WAIT;
        end
        else if (nxt_st.sleepReq)
        begin
          nxt_st.state = MODE_SLEEP_WAIT;
        end
      end
      MODE_INIT_WAIT:
      begin
        if (!busy)
        begin
          nxt_st.state = MODE_INIT; // [RULE_08]
          nxt_st.initAck = 1'b1;
        end
      end
      MODE_INIT:
      begin
        if (!nxt_st.initReq)
        begin
          nxt_st.state = MODE_SYNC;
        end
      end
      MODE_SLEEP_WAIT:
      begin
        if (nxt_st.initReq)
        begin
          nxt_st.state = MODE_INIT_WAIT;
        end
        else if (!nxt_st.sleepReq)
        begin
          nxt_st.state = MODE_NORMAL;
        end
        else if (!busy)
        begin
          nxt_st.state = MODE_SLEEP; // [RULE_06]
        end
      end
      default:
      begin
        nxt_st.state = MODE_SLEEP;
      end
    endcase

    // ----- Bus-off -----
    if (busOffEnter)
    begin
      nxt_st.busOff = 1'b1;
      nxt_st.busOffRuns = '0;
    end
    else if (st_ff.busOff && !st_ff.autoBusoff && (st_ff.state == MODE_INIT))
    begin
      nxt_st.busOff = 1'b0; // [RULE_01]
      nxt_st.busOffRuns = '0;
    end
    else if (st_ff.busOff && st_ff.autoBusoff && runDone)
    begin
      if (st_ff.busOffRuns == GROUP_LAST)
      begin
        nxt_st.busOff = 1'b0; // [RULE_01]
        nxt_st.busOffRuns = '0;
      end
      else
      begin
        nxt_st.busOffRuns = GW'(st_ff.busOffRuns + 1'b1);
      end
    end

    if (errorEvent)
    begin
      nxt_st.errFlag = 1'b1; // [RULE_12]
    end

    // ----- Transmit requests and aborts -----
    for (int i = 0; i < 2; i++)
    begin
      if (req[BIT_REQUEST0 + i] && !st_ff.pending[i])
      begin
        nxt_st.pending[i] = 1'b1;
        nxt_st.success[i] = 1'b0; // [RULE_14]
      end
      if (req[BIT_ABORT0 + i] && st_ff.pending[i])
      begin
        // An abort cannot stop a frame on the wire; it waits for the result
        if (st_ff.inFlight && (st_ff.flightMb == 1'(i)))
        begin
          nxt_st.abortReq[i] = 1'b1;
        end
        else
        begin
          nxt_st.pending[i] = 1'b0;
          nxt_st.done[i] = 1'b1; // [RULE_15]
        end
      end
    end
    if (req[BIT_REQUEST0] && !st_ff.pending[0] && req[BIT_REQUEST0 + 1] && !st_ff.pending[1])
    begin
      nxt_st.olderMb = 1'b0;
    end
    else if (req[BIT_REQUEST0] && !st_ff.pending[0])
    begin
      nxt_st.olderMb = st_ff.pending[1];
    end
    else if (req[BIT_REQUEST0 + 1] && !st_ff.pending[1])
    begin
      nxt_st.olderMb = !st_ff.pending[0];
    end

    // ----- Transmit results and start -----
    if (st_ff.inFlight && (txResultOk || txResultFail))
    begin
      nxt_st.inFlight = 1'b0;
      if (txResultOk)
      begin
        nxt_st.pending[m] = 1'b0;
        nxt_st.success[m] = 1'b1; // [RULE_14]
        nxt_st.done[m] = 1'b1; // [RULE_15]
        nxt_st.abortReq[m] = 1'b0;
      end
      else if (st_ff.singleShot || st_ff.abortReq[m])
      begin
        nxt_st.pending[m] = 1'b0; // [RULE_03]
        nxt_st.done[m] = 1'b1; // [RULE_15]
        nxt_st.abortReq[m] = 1'b0;
      end
    end
    else if (!st_ff.inFlight && (st_ff.state == MODE_NORMAL) && !st_ff.busOff && txEngineIdle
             && (st_ff.pending != 2'b00))
    begin
      // A failed frame stays pending and re-enters arbitration here
      nxt_st.inFlight = 1'b1; // [RULE_03]
      nxt_st.flightMb = winMb; // [RULE_05]
      nxt_st.txStart = 1'b1;
    end

    // ----- Receive FIFO -----
    if (rel)
    begin
      cnt = 2'(cnt - 2'h1); // [RULE_21]
      nxt_st.full = 1'b0; // [RULE_22]
      nxt_st.fifoRelease = 1'b1; // [RULE_20]
    end
    if (rxStore)
    begin
      if (cnt != FIFO_DEPTH)
      begin
        cnt = 2'(cnt + 2'h1); // [RULE_21]
        nxt_st.rxAccept = 1'b1;
        if (cnt == FIFO_DEPTH)
        begin
          nxt_st.full = 1'b1; // [RULE_22]
        end
      end
      else
      begin
        nxt_st.overrun = 1'b1; // [RULE_23]
        nxt_st.rxOverwrite = !st_ff.lockMode; // [RULE_04]
      end
    end
    nxt_st.fifoCount = cnt;

    // ----- Read data, one cycle after the strobe -----
    if (regRd)
    begin
      case (regAddr)
        OFS_MASTER_CONTROL:
        begin
          nxt_st.rdata = {1'b0, st_ff.autoBusoff, st_ff.autoWake, st_ff.singleShot,
                          st_ff.lockMode, st_ff.orderByReq, st_ff.sleepReq, st_ff.initReq};
        end
        OFS_MASTER_STATUS:
        begin
          // [RULE_10] [RULE_13]
          nxt_st.rdata = {2'b00, rxActive, txActive, st_ff.wakeFlag, st_ff.errFlag,
                          st_ff.state == MODE_SLEEP, st_ff.initAck};
        end
        OFS_TRANSMIT_STATUS:
        begin
          nxt_st.rdata = {2'b00, st_ff.success, 2'b00, st_ff.done};
        end
        OFS_TRANSMIT_PRIORITY:
        begin
          // [RULE_16] [RULE_17]
          nxt_st.rdata = {1'b0, bothPending & lowMb, bothPending & ~lowMb, 1'b0,
                          ~st_ff.pending, mbCode};
        end
        OFS_RECEIVE_FIFO_STATUS:
        begin
          // [RULE_19]
          nxt_st.rdata = {2'b00, 1'b0, st_ff.overrun, st_ff.full, 1'b0, st_ff.fifoCount};
        end
        OFS_MAILBOX_REQUEST:
        begin
          nxt_st.rdata = {2'b00, st_ff.abortReq, 2'b00, st_ff.pending};
        end
        OFS_IRQ_ENABLE:
        begin
          nxt_st.rdata = {st_ff.wakeIrqEn, st_ff.errIrqEn, 6'h00};
        end
        default:
        begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_ff <= '0;
      st_ff.state <= MODE_SLEEP;
      st_ff.sleepReq <= RST_MASTER_CONTROL[BIT_SLEEP_REQ];
      st_ff.rxMeta <= 1'b1;
      st_ff.rxSync <= 1'b1;
      st_ff.rxPrev <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata = st_ff.rdata;
  assign txStart = st_ff.txStart;
  assign txMailbox = st_ff.flightMb;
  assign rxStoreAccept = st_ff.rxAccept;
  assign rxOverwrite = st_ff.rxOverwrite;
  assign fifoRelease = st_ff.fifoRelease;
  assign initMode = (st_ff.state == MODE_INIT);
  assign sleepMode = (st_ff.state == MODE_SLEEP);
  assign busOff = st_ff.busOff;
  assign busOnline = (st_ff.state == MODE_NORMAL) && !st_ff.busOff;
  assign singleShot = st_ff.singleShot;
  // [RULE_11] [RULE_12]
  assign statusChangeIrq = (st_ff.wakeFlag & st_ff.wakeIrqEn) | (st_ff.errFlag & st_ff.errIrqEn);

endmodule

// *** verilog/cmm_recessive_run.sv ***
/*
  Counter of consecutive recessive bits at the sample point.
  Assumes bitTick is a one-cycle pulse at each sample point and that
  rxLevel is already synchronised to clk.
*/
`timescale 1ns/1ps

module cmm_recessive_run
  import cmm_pkg::*;
#(
  parameter int RUN_LEN = RECESSIVE_RUN_LEN
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bit stream
  input wire logic bitTick,
  input wire logic rxLevel,
  input wire logic clear,
  // Result
  output logic runDone
);

  localparam int CW = $clog2(RUN_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(RUN_LEN - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic done;
  } cmm_run_type;

  cmm_run_type run_ff;
  cmm_run_type nxt_run;

  always_comb
  begin
    nxt_run = run_ff;
    nxt_run.done = 1'b0;
    if (clear)
    begin
      nxt_run.cnt = '0;
    end
    else if (bitTick)
    begin
      // A dominant bit restarts the run
      if (!rxLevel)
      begin
        nxt_run.cnt = '0;
      end
      else if (run_ff.cnt == LAST)
      begin
        nxt_run.cnt = '0;
        nxt_run.done = 1'b1;
      end
      else
      begin
        nxt_run.cnt = CW'(run_ff.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      run_ff <= '0;
    end
    else
    begin
      run_ff <= nxt_run;
    end
  end

  assign runDone = run_ff.done;

endmodule
